// File: rtl/d8ct_timer.sv
// two 8-bit compare-match timer channels with an APB register slave
// assumes the consumer pulses clr_a/clr_b when a transfer clears a flag
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module d8ct_timer
  import d8ct_pkg::*;
#(
  parameter int AW = 18
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  d8ct_if.timer lnk
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0][7:0] cnt;
    logic [1:0][7:0] tca;
    logic [1:0][7:0] tcb;
    logic [1:0][2:0] ctl;
    logic adc_trigger_enable;
    logic [1:0] fa;
    logic [1:0] fb;
    logic [1:0] fo;
    logic [1:0] arm_a;
    logic [1:0] arm_b;
    logic [1:0] arm_o;
    logic [1:0] req_a;
    logic [1:0] req_b;
    logic adc;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } d8ct_dev_s;

  d8ct_dev_s s_r;
  d8ct_dev_s s_nxt;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic acc;
    logic wr;
    logic rd;
    logic [15:0] idx;
    logic [7:0] wb;
    logic [7:0] nc;
    logic tick;
    logic swcnt;
    acc = psel & penable & s_r.pready;
    wr = acc & pwrite;
    rd = acc & ~pwrite;
    idx = 16'(paddr[AW-1:2]);
    wb = pwdata[7:0];
    nc = 8'h00;
    tick = 1'b0;
    swcnt = 1'b0;
    s_nxt = s_r;
    s_nxt.adc = 1'b0;
    // one wait state: data is captured, then pready ends the access
    s_nxt.pready = psel & penable & ~s_r.pready;
    if (s_nxt.pready) begin
      s_nxt.prdata = 32'h0000_0000;
      s_nxt.pslverr = 1'b0;
      unique case (idx)
        IDX_CTRL0: s_nxt.prdata[2:0] = s_r.ctl[0];
        IDX_CTRL1: s_nxt.prdata[2:0] = s_r.ctl[1];
        IDX_STAT0: s_nxt.prdata[7:0] = {s_r.fb[0], s_r.fa[0], s_r.fo[0], s_r.adc_trigger_enable, 4'h0};
        IDX_STAT1: s_nxt.prdata[7:0] = {s_r.fb[1], s_r.fa[1], s_r.fo[1], 5'h00};
        IDX_TCA0: s_nxt.prdata[7:0] = s_r.tca[0];
        IDX_TCA1: s_nxt.prdata[7:0] = s_r.tca[1];
        IDX_TCB0: s_nxt.prdata[7:0] = s_r.tcb[0];
        IDX_TCB1: s_nxt.prdata[7:0] = s_r.tcb[1];
        IDX_CNT0: s_nxt.prdata[7:0] = s_r.cnt[0];
        IDX_CNT1: s_nxt.prdata[7:0] = s_r.cnt[1];
        default: s_nxt.pslverr = 1'b1;
      endcase
    end
    for (int ch = 0; ch < 2; ch++) begin
      // a flag read as 1 arms its clear; only the completed read counts
      if (rd && idx == IDX_STAT0 + 16'(ch)) begin
        s_nxt.arm_b[ch] = s_r.arm_b[ch] | s_r.prdata[ST_MB];
        s_nxt.arm_a[ch] = s_r.arm_a[ch] | s_r.prdata[ST_MA];
        s_nxt.arm_o[ch] = s_r.arm_o[ch] | s_r.prdata[ST_OV];
      end
      if (wr && idx == IDX_STAT0 + 16'(ch)) begin
        // ones written to the flags are ignored; reserved bits are not stored [R12] [R13]
        if (!wb[ST_MB] && s_r.arm_b[ch]) s_nxt.fb[ch] = 1'b0; // [R8]
        if (!wb[ST_MA] && s_r.arm_a[ch]) s_nxt.fa[ch] = 1'b0; // [R5]
        if (!wb[ST_OV] && s_r.arm_o[ch]) s_nxt.fo[ch] = 1'b0; // [R3]
        s_nxt.arm_a[ch] = 1'b0;
        s_nxt.arm_b[ch] = 1'b0;
        s_nxt.arm_o[ch] = 1'b0;
        if (ch == 0) s_nxt.adc_trigger_enable = wb[ST_ADC_TRIGGER_ENABLE];
      end
      if (lnk.clr_a[ch]) s_nxt.fa[ch] = 1'b0; // [R6]
      if (lnk.clr_b[ch]) s_nxt.fb[ch] = 1'b0; // [R9]
      if (wr && idx == IDX_CTRL0 + 16'(ch)) s_nxt.ctl[ch] = wb[2:0];
      if (wr && idx == IDX_TCA0 + 16'(ch)) s_nxt.tca[ch] = wb;
      if (wr && idx == IDX_TCB0 + 16'(ch)) s_nxt.tcb[ch] = wb;
      swcnt = wr && idx == IDX_CNT0 + 16'(ch);
      tick = s_r.ctl[ch][CTL_RUN] & ~swcnt;
      nc = s_r.cnt[ch] + 8'h01;
      if (swcnt) begin
        s_nxt.cnt[ch] = wb; // [R14]
      end else if (tick) begin
        s_nxt.cnt[ch] = nc; // [R14]
      end
      // hardware sets come last so they win over any clear
      if (tick && s_r.cnt[ch] == CNT_MAX) s_nxt.fo[ch] = 1'b1; // [R2]
      if (tick && nc == s_r.tca[ch]) begin
        s_nxt.fa[ch] = 1'b1; // [R4]
        if (ch == 0) s_nxt.adc = s_r.adc_trigger_enable; // [R1]
      end
      if (tick && nc == s_r.tcb[ch]) s_nxt.fb[ch] = 1'b1; // [R7]
      s_nxt.req_a[ch] = s_nxt.fa[ch] & s_nxt.ctl[ch][CTL_IEA]; // [R11]
      s_nxt.req_b[ch] = s_nxt.fb[ch] & s_nxt.ctl[ch][CTL_IEB]; // [R10]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.cnt <= {2{CNT_RST}};
      s_r.tca <= {2{TC_RST}};
      s_r.tcb <= {2{TC_RST}};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign lnk.match_a_irq = s_r.req_a;
  assign lnk.match_b_irq = s_r.req_b;
  assign lnk.adc_start = s_r.adc;
endmodule : d8ct_timer

// File: inc/d8ct_pkg.sv
// constants shared by both ends of the dual 8-bit compare timer
// assumes APB (32-bit data), one clock pclk, async active-low reset presetn
// Contract
// R1: channel 0 match A requests A/D start when enabled
// R2: overflow flag sets on count wrap FF to 00
// R3: overflow clears only on read-1 then write-0
// R4: match A flag sets when count equals constant A
// R5: match A clears on read-1 then write-0
// R6: transfer activation clears match A unless disabled
// R7: match B flag sets when count equals constant B
// R8: match B clears on read-1 then write-0
// R9: transfer activation clears match B unless disabled
// R10: match B enable gates match B request
// R11: match A enable gates match A request
// R12: status bits 7..5 take only zero writes
// R13: software writes zero to reserved status bits
// R14: counter increments per tick, write wins
package d8ct_pkg;
  // ----------------------------------------------------------------
  // timer register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_CTRL0 = 16'hFF64;
  localparam logic [15:0] IDX_CTRL1 = 16'hFF65;
  localparam logic [15:0] IDX_STAT0 = 16'hFF68;
  localparam logic [15:0] IDX_STAT1 = 16'hFF69;
  localparam logic [15:0] IDX_TCA0 = 16'hFF6C;
  localparam logic [15:0] IDX_TCA1 = 16'hFF6D;
  localparam logic [15:0] IDX_TCB0 = 16'hFF6E;
  localparam logic [15:0] IDX_TCB1 = 16'hFF6F;
  localparam logic [15:0] IDX_CNT0 = 16'hFF70;
  localparam logic [15:0] IDX_CNT1 = 16'hFF71;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTL_RUN = 0;
  localparam int CTL_IEA = 1;
  localparam int CTL_IEB = 2;
  localparam int ST_MB = 7;
  localparam int ST_MA = 6;
  localparam int ST_OV = 5;
  localparam int ST_ADC_TRIGGER_ENABLE = 4;
  // ----------------------------------------------------------------
  // reset values and counter maximum
  // ----------------------------------------------------------------
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] TC_RST = 8'hFF;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  // ----------------------------------------------------------------
  // controller register offsets (bytes) and source bits
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CLEAR = 8'h04;
  localparam logic [7:0] OFS_ENABLE = 8'h08;
  localparam logic [7:0] OFS_ROUTE = 8'h0C;
  localparam int NSRC = 5;
  localparam int SRC_ADC = 4;
  localparam int ROUTE_DIS = 4;
endpackage : d8ct_pkg

// File: inc/d8ct_if.sv
// link between the timer and its request consumer
// assumes both ends on the same pclk
`timescale 1ns/1ps
interface d8ct_if;
  logic [1:0] match_a_irq;
  logic [1:0] match_b_irq;
  logic adc_start;
  logic [1:0] clr_a;
  logic [1:0] clr_b;
  modport timer (output match_a_irq, output match_b_irq, output adc_start, input clr_a, input clr_b);
  modport ctrl (input match_a_irq, input match_b_irq, input adc_start, output clr_a, output clr_b);
endinterface : d8ct_if

// File: rtl/d8ct_ctrl.sv
// request consumer: interrupt status/enable and transfer activation
// assumes requests are levels from the timer on the same pclk
`timescale 1ns/1ps
module d8ct_ctrl
  import d8ct_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  d8ct_if.ctrl lnk
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NSRC-1:0] status;
    logic [NSRC-1:0] enable;
    logic [7:0] route;
    logic [3:0] busy;
    logic [1:0] clr_a;
    logic [1:0] clr_b;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } d8ct_ctl_s;

  d8ct_ctl_s s_r;
  d8ct_ctl_s s_nxt;

  always_comb begin
    logic wr;
    logic [3:0] req;
    logic [NSRC-1:0] ev;
    logic [NSRC-1:0] clr;
    wr = psel & penable & s_r.pready & pwrite;
    req = {lnk.match_b_irq, lnk.match_a_irq};
    ev = '0;
    clr = '0;
    s_nxt = s_r;
    s_nxt.clr_a = 2'b00;
    s_nxt.clr_b = 2'b00;
    s_nxt.pready = psel & penable & ~s_r.pready;
    if (s_nxt.pready) begin
      s_nxt.prdata = 32'h0000_0000;
      s_nxt.pslverr = 1'b0;
      unique case (paddr)
        OFS_STATUS: s_nxt.prdata[NSRC-1:0] = s_r.status;
        OFS_CLEAR: s_nxt.prdata = 32'h0000_0000;
        OFS_ENABLE: s_nxt.prdata[NSRC-1:0] = s_r.enable;
        OFS_ROUTE: s_nxt.prdata[7:0] = s_r.route;
        default: s_nxt.pslverr = 1'b1;
      endcase
    end
    if (wr && paddr == OFS_CLEAR) clr = pwdata[NSRC-1:0];
    if (wr && paddr == OFS_ENABLE) s_nxt.enable = pwdata[NSRC-1:0];
    if (wr && paddr == OFS_ROUTE) s_nxt.route = pwdata[7:0];
    for (int i = 0; i < 4; i++) begin
      // busy keeps a held request from activating twice
      if (req[i] && !s_r.busy[i]) begin
        s_nxt.busy[i] = 1'b1;
        if (s_r.route[i]) begin
          // transfer route: flag cleared only when disable-select is 0
          if (!s_r.route[ROUTE_DIS + i]) begin
            if (i < 2) s_nxt.clr_a[i % 2] = 1'b1; // [R6]
            else s_nxt.clr_b[i % 2] = 1'b1; // [R9]
          end
        end else begin
          ev[i] = 1'b1; // [R10] [R11]
        end
      end else if (!req[i]) begin
        s_nxt.busy[i] = 1'b0;
      end
    end
    ev[SRC_ADC] = lnk.adc_start; // [R1]
    // set wins over a simultaneous clear
    s_nxt.status = (s_r.status & ~clr) | ev;
    s_nxt.irq = |(s_nxt.status & s_nxt.enable);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign irq = s_r.irq;
  assign lnk.clr_a = s_r.clr_a;
  assign lnk.clr_b = s_r.clr_b;
endmodule : d8ct_ctrl

// File: tb/d8ct_link_checker.sv
// checker on the link between timer and request consumer
// assumes the signals of d8ct_if, one clock pclk
`timescale 1ns/1ps
module d8ct_link_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] match_a_irq,
  input wire logic [1:0] match_b_irq,
  input wire logic adc_start,
  input wire logic [1:0] clr_a,
  input wire logic [1:0] clr_b
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // a clear may only meet a standing request, which must fall next edge
  sequence s_drop_a0;
    match_a_irq[0] ##1 !match_a_irq[0];
  endsequence
  sequence s_drop_a1;
    match_a_irq[1] ##1 !match_a_irq[1];
  endsequence
  sequence s_drop_b0;
    match_b_irq[0] ##1 !match_b_irq[0];
  endsequence
  sequence s_drop_b1;
    match_b_irq[1] ##1 !match_b_irq[1];
  endsequence
  clr_a0_drop_a: assert property (clr_a[0] |-> s_drop_a0) else $error("clear a0 bad");
  clr_a1_drop_a: assert property (clr_a[1] |-> s_drop_a1) else $error("clear a1 bad");
  clr_b0_drop_a: assert property (clr_b[0] |-> s_drop_b0) else $error("clear b0 bad");
  clr_b1_drop_a: assert property (clr_b[1] |-> s_drop_b1) else $error("clear b1 bad");
  clr_a_pulse_a: assert property (clr_a[0] |=> !clr_a[0]) else $error("clear a long");
  clr_b_pulse_a: assert property (clr_b[0] |=> !clr_b[0]) else $error("clear b long");
  adc_pulse_a: assert property (adc_start |=> !adc_start) else $error("adc start long");
  a1_pulse_a: assert property (clr_a[1] |=> !clr_a[1]) else $error("clear a1 long");
endmodule : d8ct_link_checker

// File: tb/dual_8bit_compare_timer_tb.sv
// self-checking bench: timer and consumer joined by d8ct_if
// assumes both APB slaves answer with one wait state
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module dual_8bit_compare_timer_tb;
  import d8ct_pkg::*;
  typedef struct {bit c; bit w; logic [17:0] a; logic [31:0] d; logic [31:0] q; logic e;} d8ct_row_s;
  logic pclk = 0, presetn = 0, ps_t = 0, ps_c = 0, pen = 0, pwr = 0, rdy_t, rdy_c, er_t, er_c, irq, e;
  logic [17:0] pa = 0;
  logic [31:0] pwd = 0, rd_t, rd_c, q;
  int n_tests = 0, n_mismatch = 0;
  // --------------------------------------------------------------
  // ordinary cases: c picks the consumer, w a write
  // --------------------------------------------------------------
  d8ct_row_s rows[12] = '{
    '{0, 0, {IDX_TCA0, 2'b00}, 0, 32'hFF, 0}, '{0, 0, {IDX_TCB1, 2'b00}, 0, 32'hFF, 0},
    '{0, 0, {IDX_CNT1, 2'b00}, 0, 32'h00, 0}, '{0, 1, {IDX_TCA0, 2'b00}, 32'h10, 0, 0},
    '{0, 0, {IDX_TCA0, 2'b00}, 0, 32'h10, 0}, '{0, 1, {IDX_STAT0, 2'b00}, 32'hF0, 0, 0},
    '{0, 0, {IDX_STAT0, 2'b00}, 0, 32'h10, 0}, '{0, 0, 18'h3FC00, 0, 32'h0, 1},
    '{1, 1, {10'h0, OFS_ENABLE}, 32'h1F, 0, 0}, '{1, 0, {10'h0, OFS_ENABLE}, 0, 32'h1F, 0},
    '{1, 0, {10'h0, OFS_CLEAR}, 0, 32'h0, 0}, '{1, 0, 18'h10, 0, 32'h0, 1}};
  d8ct_if lnk();
  d8ct_timer u_d8ct_timer (.pclk(pclk), .presetn(presetn), .psel(ps_t), .penable(pen), .pwrite(pwr),
    .paddr(pa), .pwdata(pwd), .prdata(rd_t), .pready(rdy_t), .pslverr(er_t), .lnk(lnk.timer));
  d8ct_ctrl u_d8ct_ctrl (.pclk(pclk), .presetn(presetn), .psel(ps_c), .penable(pen), .pwrite(pwr),
    .paddr(pa[7:0]), .pwdata(pwd), .prdata(rd_c), .pready(rdy_c), .pslverr(er_c), .irq(irq),
    .lnk(lnk.ctrl));
  d8ct_link_checker u_d8ct_link_checker (.pclk(pclk), .presetn(presetn), .match_a_irq(lnk.match_a_irq),
    .match_b_irq(lnk.match_b_irq), .adc_start(lnk.adc_start), .clr_a(lnk.clr_a), .clr_b(lnk.clr_b));
  always #2.5 pclk = ~pclk;
  function automatic logic [17:0] ta(input logic [15:0] i);
    return {i, 2'b00};
  endfunction : ta
  // pready is sampled before the edge's own updates land
  task automatic bus(input bit c, input bit w, input logic [17:0] a, input logic [31:0] d);
    @(posedge pclk);
    ps_t <= !c;
    ps_c <= c;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge pclk);
    pen <= 1'b1;
    // no cycle limit here: only the watchdog ends a wait
    do begin
      @(posedge pclk);
    end while ((c ? rdy_c : rdy_t) !== 1'b1);
    q = c ? rd_c : rd_t;
    e = c ? er_c : er_t;
    ps_t <= 1'b0;
    ps_c <= 1'b0;
    pen <= 1'b0;
  endtask : bus
  task results;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  initial begin
    #100us;
    n_mismatch++;
    results();
  end
  initial begin
    repeat (16) @(posedge pclk);
    `CHK(irq, 1'b0)
    presetn <= 1'b1;
    foreach (rows[i]) begin
      bus(rows[i].c, rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) `CHK(q, rows[i].q)
      `CHK(e, rows[i].e)
    end
    $display("table done");
    // channel 1 runs through both matches and the wrap
    bus(0, 1, ta(IDX_CNT1), 32'h10);
    bus(0, 1, ta(IDX_TCA1), 32'h20);
    bus(0, 1, ta(IDX_TCB1), 32'h40);
    bus(0, 1, ta(IDX_CTRL1), 32'h3);
    repeat (260) @(posedge pclk);
    bus(0, 1, ta(IDX_CTRL1), 32'h2);
    `CHK(lnk.match_a_irq[1], 1'b1)
    `CHK(lnk.match_b_irq[1], 1'b0)
    `CHK(irq, 1'b1)
    bus(0, 0, ta(IDX_STAT1), 0);
    `CHK(q[7:0], 8'hE0)
    bus(0, 1, ta(IDX_STAT1), 32'hE0);
    bus(0, 1, ta(IDX_STAT1), 32'h0);
    bus(0, 0, ta(IDX_STAT1), 0);
    `CHK(q[7:0], 8'hE0)
    bus(0, 1, ta(IDX_STAT1), 32'h0);
    bus(0, 0, ta(IDX_STAT1), 0);
    `CHK(q[7:0], 8'h00)
    `CHK(lnk.match_a_irq[1], 1'b0)
    bus(1, 1, {10'h0, OFS_CLEAR}, 32'h1F);
    bus(1, 0, {10'h0, OFS_STATUS}, 0);
    `CHK(q, 32'h0)
    `CHK(irq, 1'b0)
    $display("software clear done");
    // channel 0: B taken by a transfer, A held by its disable bit
    bus(1, 1, {10'h0, OFS_ROUTE}, 32'h15);
    bus(0, 1, ta(IDX_TCB0), 32'h30);
    bus(0, 1, ta(IDX_CTRL0), 32'h7);
    repeat (80) @(posedge pclk);
    bus(0, 1, ta(IDX_CTRL0), 32'h6);
    bus(0, 0, ta(IDX_STAT0), 0);
    `CHK(q[7:0], 8'h50)
    bus(1, 0, {10'h0, OFS_STATUS}, 0);
    `CHK(q[SRC_ADC], 1'b1)
    $display("transfer clear done");
    // both channels routed with no disable: every match is taken by a transfer
    bus(0, 1, ta(IDX_STAT0), 32'h0);
    bus(1, 1, {10'h0, OFS_CLEAR}, 32'h1F);
    bus(1, 1, {10'h0, OFS_ROUTE}, 32'h0F);
    bus(0, 1, ta(IDX_CNT0), 32'h0C);
    bus(0, 1, ta(IDX_CNT1), 32'h1C);
    bus(0, 1, ta(IDX_CTRL0), 32'h7);
    bus(0, 1, ta(IDX_CTRL1), 32'h7);
    repeat (60) @(posedge pclk);
    bus(0, 1, ta(IDX_CTRL0), 32'h6);
    bus(0, 1, ta(IDX_CTRL1), 32'h6);
    bus(0, 0, ta(IDX_STAT0), 0);
    `CHK(q[7:0], 8'h00)
    bus(0, 0, ta(IDX_STAT1), 0);
    `CHK(q[7:0], 8'h00)
    bus(0, 0, ta(IDX_CNT0), 0);
    `CHK(q[7:0], 8'h50)
    bus(1, 0, {10'h0, OFS_STATUS}, 0);
    `CHK(q, 32'h0)
    `CHK(irq, 1'b0)
    $display("transfer clear all done");
    // reset in mid-run brings back the reset values
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    bus(0, 0, ta(IDX_TCA0), 0);
    `CHK(q, 32'hFF)
    bus(0, 0, ta(IDX_CNT0), 0);
    `CHK(q, 32'h0)
    bus(1, 0, {10'h0, OFS_ENABLE}, 0);
    `CHK(q, 32'h0)
    $display("mid-run reset done");
    results();
  end
endmodule : dual_8bit_compare_timer_tb
